// ==== rtl/tmo_ctrl2.sv ====
module tmo_ctrl2
   import tmo_pkg::*;
#(
   parameter bit FIRST_INSTANCE = 1'b1
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic update_generate,
   input wire logic slave_counter_reset,
   input wire logic counter_enable_bit,
   input wire logic gated_trigger_high,
   input wire logic master_slave_sync,
   input wire logic update_event,
   input wire logic channel1_event,
   input wire logic [3:0] compare_reference,
   input wire logic [3:0] compare_reference_hi,
   input wire logic center_aligned,
   input wire logic counting_down,
   input wire logic [1:0] center_trigger_direction,
   input wire logic main_output_enable,
   input wire logic dead_time_done,
   input wire logic [3:0] capcmp_event,
   input wire logic [2:0] channel_pin,
   input wire logic trigger_input,
   input wire logic commutation_generate,
   input wire logic [TMO_NCH*TMO_CFGW-1:0] chan_cfg_wr,
   output logic trigger_output,
   output logic [3:0] adc_trigger,
   output logic [TMO_NCH-1:0] idle_out,
   output logic [TMO_NCOMP-1:0] idle_comp_out,
   output logic idle_drive,
   output logic timer_input1,
   output logic [3:0] capcmp_dma_req,
   output logic commutation_event,
   output logic [TMO_NCH*TMO_CFGW-1:0] chan_cfg_act
);
   // ======================================================
   // reset release and pin synchronisers
   logic rst_s1;
   logic rst_core_b;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_s1 <= 1'b0;
         rst_core_b <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_core_b <= rst_s1;
      end
   end

   tmo_sync_if sif ();
   assign sif.pin_raw = channel_pin;
   tmo_sync2 #(.WIDTH(3)) u_sync (
      .clk(clk),
      .rst_core_b(rst_core_b),
      .sif(sif)
   );

   // ======================================================
   // register
   logic [31:0] ctrl2;
   wire [31:0] impl_mask = FIRST_INSTANCE ? TMO_CTRL2_MASK_FULL : TMO_CTRL2_MASK_LITE;
   wire sel_ctrl2 = (reg_addr == TMO_CTRL2_OFS);
   wire wr_ctrl2 = reg_write && sel_ctrl2;
   // reserved bits are not stored, so writes to them cannot disturb logic
   wire [31:0] next_ctrl2 = reg_wdata & impl_mask;
   wire [31:0] next_rdata = sel_ctrl2 ? ctrl2 : 32'h0000_0000;

   always_ff @(posedge clk or negedge rst_core_b)
   begin
      if (!rst_core_b)
         ctrl2 <= TMO_CTRL2_RST;
      else if (wr_ctrl2)
         ctrl2 <= next_ctrl2;
   end

   always_ff @(posedge clk or negedge rst_core_b)
   begin
      if (!rst_core_b)
         reg_rdata <= 32'h0000_0000;
      else if (reg_read)
         reg_rdata <= next_rdata;
      else
         reg_rdata <= 32'h0000_0000;
   end

   // ======================================================
   // master trigger output
   wire [3:0] master_sel = {ctrl2[TMO_B_MMS_HI], ctrl2[TMO_B_MMS_LO+2:TMO_B_MMS_LO]};

   // gated path is held back one cycle while master_slave_sync is low so slaves see it aligned with the counter
   logic gate_dly;
   always_ff @(posedge clk or negedge rst_core_b)
   begin
      if (!rst_core_b)
         gate_dly <= 1'b0;
      else
         gate_dly <= gated_trigger_high;
   end
   wire gate_term = master_slave_sync ? gated_trigger_high : gate_dly;
   wire cnt_en_sig = counter_enable_bit || gate_term;

   // slave reset pulse comes one cycle after the counter reset itself
   logic slave_rst_dly;
   always_ff @(posedge clk or negedge rst_core_b)
   begin
      if (!rst_core_b)
         slave_rst_dly <= 1'b0;
      else
         slave_rst_dly <= slave_counter_reset;
   end
   wire reset_pulse = update_generate || slave_rst_dly;

   // edges of the high compare references: ch4, ch7, ch8, ch9
   logic [3:0] hi_ref_q;
   always_ff @(posedge clk or negedge rst_core_b)
   begin
      if (!rst_core_b)
         hi_ref_q <= 4'h0;
      else
         hi_ref_q <= compare_reference_hi;
   end
   wire any_hi_edge = |(compare_reference_hi & ~hi_ref_q);
   wire dir_ok = center_trigger_direction[1] ||
                 (center_trigger_direction[0] == counting_down);
   wire center_trig = any_hi_edge && dir_ok;
   wire hi_trig = center_aligned ? center_trig : compare_reference[3];

   logic next_trigger_output;
   always_comb
   begin
      next_trigger_output = 1'b0;
      if (master_sel[3])
         next_trigger_output = hi_trig;
      else
      begin
         case (master_sel[2:0])
            3'h0: next_trigger_output = reset_pulse;
            3'h1: next_trigger_output = cnt_en_sig;
            3'h2: next_trigger_output = update_event;
            3'h3: next_trigger_output = channel1_event;
            3'h4: next_trigger_output = compare_reference[0];
            3'h5: next_trigger_output = compare_reference[1];
            3'h6: next_trigger_output = compare_reference[2];
            3'h7: next_trigger_output = compare_reference[3];
            default: next_trigger_output = 1'b0;
         endcase
      end
   end

   // ======================================================
   // ADC triggers and idle levels
   wire [3:0] trig_en = {ctrl2[TMO_B_CH9_ADC_TRIGGER_EN], ctrl2[TMO_B_CH8_ADC_TRIGGER_EN], ctrl2[TMO_B_CH7_ADC_TRIGGER_EN], ctrl2[TMO_B_CH4_ADC_TRIGGER_EN]};
   wire [3:0] next_adc = compare_reference_hi & trig_en;
   wire [5:0] idle_lv = {ctrl2[TMO_B_IDLE6], ctrl2[TMO_B_IDLE5], ctrl2[TMO_B_IDLE4],
                         ctrl2[TMO_B_IDLE3], ctrl2[TMO_B_IDLE2], ctrl2[TMO_B_IDLE1]};
   wire [2:0] idle_comp_lv = {ctrl2[TMO_B_IDLE3N], ctrl2[TMO_B_IDLE2N], ctrl2[TMO_B_IDLE1N]};
   // ch4 complementary idle sits apart at bit 17; exported through bit 2 group only for ch1-3
   wire next_idle_drive = !main_output_enable && dead_time_done;

   // ======================================================
   // input select, DMA select
   wire next_ti1 = ctrl2[TMO_B_XORSEL] ? ^sif.pin_sync : sif.pin_sync[0];
   wire [3:0] next_dma = ctrl2[TMO_B_DMASEL] ? {4{update_event}} : capcmp_event;

   // ======================================================
   // commutation and preload
   logic trigger_input_q;
   always_ff @(posedge clk or negedge rst_core_b)
   begin
      if (!rst_core_b)
         trigger_input_q <= 1'b0;
      else
         trigger_input_q <= trigger_input;
   end
   wire trigger_input_rise = trigger_input && !trigger_input_q;
   wire next_com = commutation_generate || (ctrl2[TMO_B_COMSRC] && trigger_input_rise);
   wire preload_on = ctrl2[TMO_B_PRELOAD];

   logic [TMO_NCH*TMO_CFGW-1:0] cfg_shadow;
   logic [TMO_NCH*TMO_CFGW-1:0] next_cfg_act;
   genvar gc;
   generate
      for (gc = 0; gc < TMO_NCH; gc++)
      begin : g_cfg
         // only complementary channels wait for commutation
         if (gc < 4)
         begin : g_comp
            assign next_cfg_act[gc*TMO_CFGW +: TMO_CFGW] =
               !preload_on ? chan_cfg_wr[gc*TMO_CFGW +: TMO_CFGW] :
               (next_com ? chan_cfg_wr[gc*TMO_CFGW +: TMO_CFGW] :
                cfg_shadow[gc*TMO_CFGW +: TMO_CFGW]);
         end
         else
         begin : g_plain
            assign next_cfg_act[gc*TMO_CFGW +: TMO_CFGW] = chan_cfg_wr[gc*TMO_CFGW +: TMO_CFGW];
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_core_b)
   begin
      if (!rst_core_b)
         cfg_shadow <= '0;
      else
         cfg_shadow <= next_cfg_act;
   end

   // ======================================================
   // registered outputs
   always_ff @(posedge clk or negedge rst_core_b)
   begin
      if (!rst_core_b)
      begin
         trigger_output <= 1'b0;
         adc_trigger <= 4'h0;
         idle_out <= '0;
         idle_comp_out <= '0;
         idle_drive <= 1'b0;
         timer_input1 <= 1'b0;
         capcmp_dma_req <= 4'h0;
         commutation_event <= 1'b0;
      end
      else
      begin
         trigger_output <= next_trigger_output;
         adc_trigger <= next_adc;
         idle_out <= idle_lv;
         idle_comp_out <= idle_comp_lv;
         idle_drive <= next_idle_drive;
         timer_input1 <= next_ti1;
         capcmp_dma_req <= next_dma;
         commutation_event <= next_com;
      end
   end
   assign chan_cfg_act = cfg_shadow;

   // ======================================================
   // checks
   AST_SEL_UPDATE: assert property (@(posedge clk) disable iff (!rst_core_b)
      (master_sel == 4'h2) |=> (trigger_output == $past(update_event)))
      else $error("update not on trigger output");
   AST_SEL_CC1: assert property (@(posedge clk) disable iff (!rst_core_b)
      (master_sel == 4'h3) && channel1_event |=> trigger_output)
      else $error("channel 1 pulse missing");
   AST_SEL_REF: assert property (@(posedge clk) disable iff (!rst_core_b)
      (master_sel == 4'h5) |=> (trigger_output == $past(compare_reference[1])))
      else $error("compare reference 2 not forwarded");
   AST_SEL_REF4: assert property (@(posedge clk) disable iff (!rst_core_b)
      (master_sel == 4'h7) |=> (trigger_output == $past(compare_reference[3])))
      else $error("compare reference 4 not forwarded");
   AST_SLAVE_RST: assert property (@(posedge clk) disable iff (!rst_core_b)
      (master_sel == 4'h0) && slave_counter_reset ##1 (master_sel == 4'h0) |=> trigger_output)
      else $error("delayed reset pulse missing");
   AST_SEL_RESET: assert property (@(posedge clk) disable iff (!rst_core_b)
      (master_sel == 4'h0) && update_generate |=> trigger_output)
      else $error("update generate pulse missing");
   AST_SEL_CNT: assert property (@(posedge clk) disable iff (!rst_core_b)
      (master_sel == 4'h1) && counter_enable_bit |=> trigger_output)
      else $error("counter enable not on trigger output");
   AST_GATE_SYNC: assert property (@(posedge clk) disable iff (!rst_core_b)
      (master_sel == 4'h1) && master_slave_sync |=>
      (trigger_output == $past(counter_enable_bit || gated_trigger_high)))
      else $error("synchronised enable path wrong");
   AST_GATE_DELAY: assert property (@(posedge clk) disable iff (!rst_core_b)
      (master_sel == 4'h1) && !master_slave_sync |=>
      (trigger_output == ($past(counter_enable_bit) || $past(gated_trigger_high, 2))))
      else $error("gated enable path not delayed");
   AST_EDGE_MODE: assert property (@(posedge clk) disable iff (!rst_core_b)
      master_sel[3] && !center_aligned |=> (trigger_output == $past(compare_reference[3])))
      else $error("edge mode does not forward channel 4 reference");
   AST_DIR_UP: assert property (@(posedge clk) disable iff (!rst_core_b)
      master_sel[3] && center_aligned && (center_trigger_direction == 2'h0) && counting_down |=> !trigger_output)
      else $error("up-only trigger fired while counting down");
   AST_PULSE_END: assert property (@(posedge clk) disable iff (!rst_core_b)
      (master_sel == 4'h3) && !channel1_event |=> !trigger_output)
      else $error("compare pulse longer than one cycle");
   AST_ADC_GATE: assert property (@(posedge clk) disable iff (!rst_core_b)
      !trig_en[0] |=> !adc_trigger[0])
      else $error("adc trigger while disabled");
   AST_ADC_PASS: assert property (@(posedge clk) disable iff (!rst_core_b)
      1'b1 |=> (adc_trigger == $past(compare_reference_hi & trig_en)))
      else $error("enabled adc trigger not passed");
   AST_IDLE_DRIVE: assert property (@(posedge clk) disable iff (!rst_core_b)
      !main_output_enable && dead_time_done |=> idle_drive)
      else $error("idle levels not driven with main output off");
   AST_IDLE_LEVEL: assert property (@(posedge clk) disable iff (!rst_core_b)
      1'b1 |=> (idle_out[0] == $past(ctrl2[TMO_B_IDLE1])))
      else $error("channel 1 idle level wrong");
   AST_IDLE_COMP: assert property (@(posedge clk) disable iff (!rst_core_b)
      1'b1 |=> (idle_comp_out[1] == $past(ctrl2[TMO_B_IDLE2N])))
      else $error("channel 2 complementary idle level wrong");
   AST_XOR_SEL: assert property (@(posedge clk) disable iff (!rst_core_b)
      ctrl2[TMO_B_XORSEL] |=> (timer_input1 == $past(^sif.pin_sync)))
      else $error("input xor select wrong");
   AST_PIN_SEL: assert property (@(posedge clk) disable iff (!rst_core_b)
      !ctrl2[TMO_B_XORSEL] |=> (timer_input1 == $past(sif.pin_sync[0])))
      else $error("input single pin select wrong");
   AST_DMA_UPD: assert property (@(posedge clk) disable iff (!rst_core_b)
      ctrl2[TMO_B_DMASEL] && update_event |=> (capcmp_dma_req == 4'hF))
      else $error("dma on update missing");
   AST_DMA_CC: assert property (@(posedge clk) disable iff (!rst_core_b)
      !ctrl2[TMO_B_DMASEL] |=> (capcmp_dma_req == $past(capcmp_event)))
      else $error("dma on channel event wrong");
   AST_COM_SRC: assert property (@(posedge clk) disable iff (!rst_core_b)
      !ctrl2[TMO_B_COMSRC] && !commutation_generate |=> !commutation_event)
      else $error("commutation without source");
   AST_COM_APPLY: assert property (@(posedge clk) disable iff (!rst_core_b)
      preload_on && commutation_generate |=> (chan_cfg_act == $past(chan_cfg_wr)))
      else $error("commutation did not apply preloaded bits");
   AST_PRELOAD_HOLD: assert property (@(posedge clk) disable iff (!rst_core_b)
      preload_on && !next_com |=> $stable(cfg_shadow[4*TMO_CFGW-1:0]))
      else $error("preloaded bits changed without commutation");
   AST_PRELOAD_OFF: assert property (@(posedge clk) disable iff (!rst_core_b)
      !preload_on |=> (chan_cfg_act == $past(chan_cfg_wr)))
      else $error("bits not applied directly without preload");
   AST_PLAIN_CH: assert property (@(posedge clk) disable iff (!rst_core_b)
      1'b1 |=> (chan_cfg_act[6*TMO_CFGW-1:4*TMO_CFGW] == $past(chan_cfg_wr[6*TMO_CFGW-1:4*TMO_CFGW])))
      else $error("plain channel waited for commutation");
   AST_RESERVED: assert property (@(posedge clk) disable iff (!rst_core_b)
      (ctrl2 & ~impl_mask) == 32'h0000_0000)
      else $error("unimplemented bit stored");
   COV_GATED: cover property (@(posedge clk) disable iff (!rst_core_b)
      (master_sel == 4'h1) && gated_trigger_high && !master_slave_sync);
   COV_CENTER: cover property (@(posedge clk) disable iff (!rst_core_b)
      master_sel[3] && center_aligned && center_trig);
   COV_COM_TRIGGER_INPUT: cover property (@(posedge clk) disable iff (!rst_core_b)
      preload_on && ctrl2[TMO_B_COMSRC] && trigger_input_rise);
   COV_SLAVE_RST: cover property (@(posedge clk) disable iff (!rst_core_b)
      (master_sel == 4'h0) && slave_rst_dly);
endmodule : tmo_ctrl2

// ==== rtl/tmo_pkg.sv ====
package tmo_pkg;
   localparam logic [7:0] TMO_CTRL2_OFS = 8'h04;
   localparam logic [31:0] TMO_CTRL2_RST = 32'h0000_0000;
   // bits 22 and 20 are reserved, so the upper nibble of byte two is 1010
   localparam logic [31:0] TMO_CTRL2_MASK_FULL = 32'h01AF_FFFD;
   localparam logic [31:0] TMO_CTRL2_MASK_LITE = 32'h0007_7FFD;
   localparam int TMO_B_PRELOAD = 0;
   localparam int TMO_B_COMSRC = 2;
   localparam int TMO_B_DMASEL = 3;
   localparam int TMO_B_MMS_LO = 4;
   localparam int TMO_B_XORSEL = 7;
   localparam int TMO_B_IDLE1 = 8;
   localparam int TMO_B_IDLE1N = 9;
   localparam int TMO_B_IDLE2 = 10;
   localparam int TMO_B_IDLE2N = 11;
   localparam int TMO_B_IDLE3 = 12;
   localparam int TMO_B_IDLE3N = 13;
   localparam int TMO_B_IDLE4 = 14;
   localparam int TMO_B_CH4_ADC_TRIGGER_EN = 15;
   localparam int TMO_B_IDLE5 = 16;
   localparam int TMO_B_IDLE4N = 17;
   localparam int TMO_B_IDLE6 = 18;
   localparam int TMO_B_CH7_ADC_TRIGGER_EN = 19;
   localparam int TMO_B_CH8_ADC_TRIGGER_EN = 21;
   localparam int TMO_B_CH9_ADC_TRIGGER_EN = 23;
   localparam int TMO_B_MMS_HI = 24;
   localparam int TMO_NCH = 6;
   localparam int TMO_NCOMP = 3;
   // per channel: enable, complementary enable, 3-bit mode
   localparam int TMO_CFGW = 5;
endpackage : tmo_pkg

// ==== rtl/tmo_sync_if.sv ====
interface tmo_sync_if;
   logic [2:0] pin_raw;
   logic [2:0] pin_sync;
   modport src (output pin_raw, input pin_sync);
   modport dst (input pin_raw, output pin_sync);
endinterface : tmo_sync_if

// ==== rtl/tmo_sync2.sv ====
module tmo_sync2
   import tmo_pkg::*;
#(
   parameter int WIDTH = 3
)
(
   input wire logic clk,
   input wire logic rst_core_b,
   tmo_sync_if.dst sif
);
   initial
   begin
      if (WIDTH != 3)
         $error("tmo_sync2 carries exactly the three channel pins");
   end
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   assign sif.pin_sync = stage2;
   always_ff @(posedge clk or negedge rst_core_b)
   begin
      if (!rst_core_b)
      begin
         stage1 <= '0;
         stage2 <= '0;
      end
      else
      begin
         stage1 <= sif.pin_raw;
         stage2 <= stage1;
      end
   end
endmodule : tmo_sync2

// ==== verif/tmo_slave_model.sv ====
// ==========================================
// slave timer seen from the master side
module tmo_slave_model
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic trigger_output,
   output logic [15:0] slave_ticks
);
   timeunit 1ns;
   timeprecision 100ps;
   logic trg_q;
   // prescaler of the slave advances once per rising trigger edge
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         trg_q <= 1'h0;
         slave_ticks <= 16'h0000;
      end
      else
      begin
         trg_q <= trigger_output;
         if (trigger_output && !trg_q)
         begin
            slave_ticks <= slave_ticks + 16'h0001;
         end
      end
   end
endmodule : tmo_slave_model

// ==== verif/tmo_ctrl2_tb.sv ====
module tmo_ctrl2_tb
   import tmo_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] ofs = TMO_CTRL2_OFS;
   logic clk = 1'h0, rst_b = 1'h0, reg_write = 1'h0, reg_read = 1'h0, update_generate = 1'h0;
   logic slave_counter_reset = 1'h0, counter_enable_bit = 1'h0, gated_trigger_high = 1'h0;
   logic master_slave_sync = 1'h0, update_event = 1'h0, channel1_event = 1'h0, center_aligned = 1'h0;
   logic counting_down = 1'h0, main_output_enable = 1'h1, dead_time_done = 1'h0, trigger_input = 1'h0;
   logic commutation_generate = 1'h0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [3:0] compare_reference = 4'h0, compare_reference_hi = 4'h0, capcmp_event = 4'h0;
   logic [1:0] center_trigger_direction = 2'h0;
   logic [2:0] channel_pin = 3'h0, idle_comp_out;
   logic [29:0] chan_cfg_wr = 30'h0, chan_cfg_act;
   logic trigger_output, idle_drive, timer_input1, commutation_event;
   logic [3:0] adc_trigger, capcmp_dma_req;
   logic [5:0] idle_out;
   logic [15:0] slave_ticks;
   int n_errors = 0, compares = 0, cycles = 0;
   tmo_ctrl2 #(.FIRST_INSTANCE(1'h1)) dut_u
   (
      .clk, .rst_b, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .update_generate,
      .slave_counter_reset, .counter_enable_bit, .gated_trigger_high, .master_slave_sync, .update_event,
      .channel1_event, .compare_reference, .compare_reference_hi, .center_aligned, .counting_down,
      .center_trigger_direction, .main_output_enable, .dead_time_done, .capcmp_event, .channel_pin,
      .trigger_input, .commutation_generate, .chan_cfg_wr, .trigger_output, .adc_trigger, .idle_out,
      .idle_comp_out, .idle_drive, .timer_input1, .capcmp_dma_req, .commutation_event, .chan_cfg_act
   );
   tmo_slave_model slave_u (.clk, .rst_b, .trigger_output, .slave_ticks);
   initial
   begin
      forever #25 clk = ~clk;
   end
   // ==========================================
   // shared bus and compare tasks
   task automatic at(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : at
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_write <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_read <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'h0;
      at(0);
      chk("reg_rdata", exp, reg_rdata);
   endtask : rd
   task automatic end_sim();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim
   // ==========================================
   // scenarios
   task automatic t_regs();
      rd(ofs, TMO_CTRL2_RST);
      wr(ofs, 32'hFFFF_FFFF);
      rd(ofs, TMO_CTRL2_MASK_FULL);
      wr(8'h08, 32'h0);
      rd(ofs, TMO_CTRL2_MASK_FULL);
      rd(8'h08, 32'h0);
   endtask : t_regs
   task automatic t_events();
      int t0;
      wr(ofs, 32'h0);
      @(posedge clk);
      update_generate <= 1'h1;
      @(posedge clk);
      update_generate <= 1'h0;
      at(0);
      chk("trigger_output", 1'h1, trigger_output);
      at(1);
      chk("trigger_output", 1'h0, trigger_output);
      @(posedge clk);
      slave_counter_reset <= 1'h1;
      @(posedge clk);
      slave_counter_reset <= 1'h0;
      at(0);
      chk("trigger_output", 1'h0, trigger_output);
      at(1);
      chk("trigger_output", 1'h1, trigger_output);
      wr(ofs, 32'h20);
      t0 = slave_ticks;
      repeat (3)
      begin
         @(posedge clk);
         update_event <= 1'h1;
         @(posedge clk);
         update_event <= 1'h0;
         at(0);
         chk("trigger_output", 1'h1, trigger_output);
      end
      at(2);
      chk("slave_ticks", 32'(t0 + 3), 32'(slave_ticks));
      wr(ofs, 32'h30);
      repeat (2)
      begin
         @(posedge clk);
         channel1_event <= 1'h1;
         @(posedge clk);
         channel1_event <= 1'h0;
         at(0);
         chk("trigger_output", 1'h1, trigger_output);
         at(1);
         chk("trigger_output", 1'h0, trigger_output);
      end
   endtask : t_events
   task automatic t_enable();
      wr(ofs, 32'h10);
      @(posedge clk);
      counter_enable_bit <= 1'h1;
      at(1);
      chk("trigger_output", 1'h1, trigger_output);
      @(posedge clk);
      counter_enable_bit <= 1'h0;
      gated_trigger_high <= 1'h1;
      at(1);
      chk("trigger_output", 1'h0, trigger_output);
      at(1);
      chk("trigger_output", 1'h1, trigger_output);
      @(posedge clk);
      gated_trigger_high <= 1'h0;
      master_slave_sync <= 1'h1;
      at(3);
      chk("trigger_output", 1'h0, trigger_output);
      @(posedge clk);
      gated_trigger_high <= 1'h1;
      at(1);
      chk("trigger_output", 1'h1, trigger_output);
      @(posedge clk);
      gated_trigger_high <= 1'h0;
      master_slave_sync <= 1'h0;
   endtask : t_enable
   task automatic t_compare();
      logic [1:0] dir_t [5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
      logic dn_t [5] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h1};
      logic ex_t [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
      for (int i = 0; i < 4; i++)
      begin
         wr(ofs, 32'h40 + 32'(i) * 32'h10);
         @(posedge clk);
         compare_reference <= 4'h1 << i;
         at(1);
         chk("trigger_output", 1'h1, trigger_output);
         @(posedge clk);
         compare_reference <= ~(4'h1 << i);
         at(1);
         chk("trigger_output", 1'h0, trigger_output);
      end
      wr(ofs, 32'h0100_0000);
      @(posedge clk);
      compare_reference <= 4'h8;
      compare_reference_hi <= 4'h1;
      at(1);
      chk("trigger_output", 1'h1, trigger_output);
      @(posedge clk);
      compare_reference <= 4'h0;
      compare_reference_hi <= 4'h0;
      center_aligned <= 1'h1;
      for (int i = 0; i < 5; i++)
      begin
         @(posedge clk);
         center_trigger_direction <= dir_t[i];
         counting_down <= dn_t[i];
         at(2);
         @(posedge clk);
         compare_reference_hi <= 4'h2;
         at(1);
         chk("trigger_output", ex_t[i], trigger_output);
         @(posedge clk);
         compare_reference_hi <= 4'h0;
      end
      @(posedge clk);
      center_aligned <= 1'h0;
   endtask : t_compare
   task automatic t_adc_idle();
      wr(ofs, 32'h0088_0000);
      @(posedge clk);
      compare_reference_hi <= 4'hF;
      at(1);
      chk("adc_trigger", 4'hA, adc_trigger);
      wr(ofs, 32'h0000_8000);
      at(1);
      chk("adc_trigger", 4'h1, adc_trigger);
      wr(ofs, 32'h0004_5900);
      @(posedge clk);
      compare_reference_hi <= 4'h0;
      main_output_enable <= 1'h0;
      dead_time_done <= 1'h1;
      at(1);
      chk("idle_drive", 1'h1, idle_drive);
      chk("idle_out", 6'h2D, idle_out);
      chk("idle_comp_out", 3'h2, idle_comp_out);
      @(posedge clk);
      dead_time_done <= 1'h0;
      at(1);
      chk("idle_drive", 1'h0, idle_drive);
      @(posedge clk);
      dead_time_done <= 1'h1;
      main_output_enable <= 1'h1;
      at(1);
      chk("idle_drive", 1'h0, idle_drive);
   endtask : t_adc_idle
   task automatic t_route();
      wr(ofs, 32'h0);
      @(posedge clk);
      channel_pin <= 3'h2;
      at(4);
      chk("timer_input1", 1'h0, timer_input1);
      wr(ofs, 32'h80);
      at(2);
      chk("timer_input1", 1'h1, timer_input1);
      @(posedge clk);
      channel_pin <= 3'h3;
      at(4);
      chk("timer_input1", 1'h0, timer_input1);
      wr(ofs, 32'h0);
      at(2);
      chk("timer_input1", 1'h1, timer_input1);
      for (int s = 0; s < 2; s++)
      begin
         wr(ofs, (s == 1) ? 32'h8 : 32'h0);
         @(posedge clk);
         capcmp_event <= 4'h5;
         @(posedge clk);
         capcmp_event <= 4'h0;
         at(0);
         chk("capcmp_dma_req", (s == 1) ? 4'h0 : 4'h5, capcmp_dma_req);
         @(posedge clk);
         update_event <= 1'h1;
         @(posedge clk);
         update_event <= 1'h0;
         at(0);
         chk("capcmp_dma_req", (s == 1) ? 4'hF : 4'h0, capcmp_dma_req);
      end
   endtask : t_route
   task automatic t_preload();
      wr(ofs, 32'h0);
      @(posedge clk);
      chan_cfg_wr <= 30'h1555_5555;
      at(1);
      chk("chan_cfg_act", 30'h1555_5555, chan_cfg_act);
      wr(ofs, 32'h1);
      @(posedge clk);
      chan_cfg_wr <= 30'h2AAA_AAAA;
      trigger_input <= 1'h1;
      at(3);
      chk("chan_cfg_act", 30'h2AA5_5555, chan_cfg_act);
      @(posedge clk);
      commutation_generate <= 1'h1;
      @(posedge clk);
      commutation_generate <= 1'h0;
      at(0);
      chk("commutation_event", 1'h1, commutation_event);
      at(1);
      chk("chan_cfg_act", 30'h2AAA_AAAA, chan_cfg_act);
      @(posedge clk);
      trigger_input <= 1'h0;
      chan_cfg_wr <= 30'h0333_3333;
      wr(ofs, 32'h5);
      @(posedge clk);
      trigger_input <= 1'h1;
      at(3);
      chk("chan_cfg_act", 30'h0333_3333, chan_cfg_act);
   endtask : t_preload
   // ==========================================
   // run control
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         n_errors++;
         end_sim();
      end
   end
   initial
   begin
      repeat (20) @(posedge clk);
      rst_b <= 1'h1;
      at(5);
      t_regs();
      t_events();
      t_enable();
      t_compare();
      t_adc_idle();
      t_route();
      t_preload();
      end_sim();
   end
endmodule : tmo_ctrl2_tb
